// ### shared/tlb_pkg.sv
// Summary of operation
// (RQ1) Privileged move-type loads and stores can read and write the TLB contents, and no other accesses can.
// (RQ2) Addresses H'F2000000 to H'F2FFFFFF select the address array (page number, valid bit, space id).
// (RQ3) Addresses H'F3000000 to H'F3FFFFFF select the data array (page number, key, size, attributes).
// (RQ4) The valid bit of an entry can be read and changed through the data array as well.
// (RQ5) Software uses only 32-bit longword accesses to both arrays.
// (RQ6) Address-array accesses take the index from bits 16-12, the way from bits 9-8 and need H'F2 in 31-24.
// (RQ7) With the index-xor enable set, the index is the address index bits XOR the space id.
// (RQ8) An address-array read returns page number, valid bit and space id of the selected entry.
// (RQ9) An address-array write stores page number, valid bit and space id into the selected entry.
// (RQ10) Data-array accesses take the index from bits 16-12, need H'F3 in 31-24, way 00..11 is way 0..3.
// (RQ11) Data-array reads and writes move the full longword of the selected entry.
// (RQ12) Software gives a 32-bit address for each access and a 32-bit data word for writes.
// (RQ13) The space id sits in data bits 7-0, and bits 16-12 of an address-array read are zero.
// (RQ14) Address bits with no select, index or way meaning are ignored during decode.
package tlb_pkg;
    localparam int SEL_MSB = 31;
    localparam int SEL_LSB = 24;
    localparam logic [7:0] ADDR_ARRAY_SEL = 8'hf2;
    localparam logic [7:0] DATA_ARRAY_SEL = 8'hf3;
    localparam int IDX_MSB = 16;
    localparam int IDX_LSB = 12;
    localparam int WAY_MSB = 9;
    localparam int WAY_LSB = 8;
    localparam int VPN_HI_MSB = 31;
    localparam int VPN_HI_LSB = 17;
    localparam int VPN_LO_MSB = 11;
    localparam int VPN_LO_LSB = 10;
    localparam int VALID_BIT = 8;
    localparam int ADDRESS_SPACE_ID_MSB = 7;
    localparam int ADDRESS_SPACE_ID_LSB = 0;
    localparam int ENTRY_BITS = 5;
    localparam int WAY_BITS = 2;
    localparam logic [31:0] CTRL_OFFSET = 32'hff00_0010;
    localparam logic [31:0] STATUS_OFFSET = 32'hff00_0014;
    localparam int CTRL_IXE_BIT = 0;
    localparam int CTRL_ADDRESS_SPACE_ID_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_ff01;
    localparam logic [3:0] FULL_STRB = 4'hf;

    typedef struct packed {
        logic [VPN_HI_MSB-VPN_HI_LSB:0] vpn_hi;
        logic [VPN_LO_MSB-VPN_LO_LSB:0] vpn_lo;
        logic valid;
        logic [ADDRESS_SPACE_ID_MSB:ADDRESS_SPACE_ID_LSB] address_space_id;
    } tlb_tag_t;

    typedef enum logic [2:0] {
        KIND_NONE = 3'b000,
        KIND_TAG = 3'b001,
        KIND_DATA = 3'b010,
        KIND_CTRL = 3'b011,
        KIND_STATUS = 3'b100
    } access_kind_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RESP = 1'b1
    } apb_state_t;

    typedef struct packed {
        access_kind_t kind;
        logic write;
        logic error;
        logic [WAY_BITS-1:0] way;
        logic [ENTRY_BITS-1:0] index;
        logic [31:0] wdata;
    } pending_t;
endpackage

// ### hdl/tlb_index_calc.sv
`timescale 1ns/10ps
`default_nettype none
module tlb_index_calc
    import tlb_pkg::*;
#(
    parameter int ENTRY_W = ENTRY_BITS
) (
    input wire logic [31:0] addr,
    input wire logic index_xor_enable,
    input wire logic [7:0] address_space_id,
    output logic [ENTRY_W-1:0] index,
    output logic [WAY_BITS-1:0] way
);
    // (RQ6) index and way
    always_comb begin
        way = addr[WAY_MSB:WAY_LSB];
        // (RQ7) optional space-id xor
        if (index_xor_enable) begin
            index = addr[IDX_LSB+ENTRY_W-1:IDX_LSB] ^ address_space_id[ENTRY_W-1:0];
        end else begin
            index = addr[IDX_LSB+ENTRY_W-1:IDX_LSB];
        end
    end
endmodule
`default_nettype wire

// ### hdl/tlb_memory_mapped_access.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module tlb_memory_mapped_access
    import tlb_pkg::*;
#(
    parameter int ENTRIES = 32,
    parameter int WAYS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int EW = $clog2(ENTRIES);

    apb_state_t state;
    apb_state_t next_state;
    pending_t pend;
    pending_t next_pend;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [7:0] err_count;
    logic [7:0] next_err_count;
    logic last_err;
    logic next_last_err;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    logic [EW-1:0] dec_index;
    logic [WAY_BITS-1:0] dec_way;
    logic tag_sel;
    logic data_sel;
    logic ctrl_sel;
    logic status_sel;
    access_kind_t dec_kind;
    tlb_tag_t way_tag [WAYS];
    logic [31:0] way_data [WAYS];
    tlb_tag_t rd_tag;
    logic [31:0] rd_data;
    logic [31:0] rd_word;
    tlb_tag_t wr_tag;
    logic priv_fault;
    logic decode_fault;
    logic size_fault;
    logic ro_fault;
    logic req_fault;
    logic take;
    logic commit;

    tlb_index_calc #(
        .ENTRY_W(EW)
    ) u_index (
        .addr(paddr),
        .index_xor_enable(ctrl[CTRL_IXE_BIT]),
        .address_space_id(ctrl[CTRL_ADDRESS_SPACE_ID_LSB+7:CTRL_ADDRESS_SPACE_ID_LSB]),
        .index(dec_index),
        .way(dec_way)
    );

    // For the arrays only the select byte takes part; control and status match the full address
    always_comb begin
        // (RQ2) address array range
        tag_sel = (paddr[SEL_MSB:SEL_LSB] == ADDR_ARRAY_SEL);
        // (RQ3) data array range
        data_sel = (paddr[SEL_MSB:SEL_LSB] == DATA_ARRAY_SEL);
        ctrl_sel = (paddr == CTRL_OFFSET);
        status_sel = (paddr == STATUS_OFFSET);
    end

    always_comb begin
        // (RQ14) ignore other bits
        if (tag_sel) begin
            dec_kind = KIND_TAG;
        end else if (data_sel) begin
            dec_kind = KIND_DATA;
        end else if (ctrl_sel) begin
            dec_kind = KIND_CTRL;
        end else if (status_sel) begin
            dec_kind = KIND_STATUS;
        end else begin
            dec_kind = KIND_NONE;
        end
        rd_tag = way_tag[dec_way];
        rd_data = way_data[dec_way];
    end

    // Taken once, in the first access cycle; the pending answer blocks a second take
    assign take = (state == ST_IDLE) && psel && penable;

    // Refusals are judged on the live request, so the answer can carry them
    always_comb begin
        // (RQ1) privileged access only
        priv_fault = !pprot[0];
        decode_fault = (dec_kind == KIND_NONE);
        // (RQ5) longword writes only
        size_fault = pwrite && (pstrb != FULL_STRB);
        // Status is read-only; a write there is refused, not silently dropped
        ro_fault = pwrite && (dec_kind == KIND_STATUS);
        req_fault = priv_fault || decode_fault || size_fault || ro_fault;
    end

    // Read word as it will stand on prdata; writes and refusals return zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (!req_fault && !pwrite) begin
            case (dec_kind)
                KIND_TAG: begin
                    // (RQ8) tag read
                    // (RQ13) bits 16-12 read zero
                    rd_word = {rd_tag.vpn_hi, 5'h00, rd_tag.vpn_lo, 1'b0, rd_tag.valid,
                        rd_tag.address_space_id};
                end
                KIND_DATA: begin
                    // (RQ11) full longword read
                    rd_word = rd_data;
                    // (RQ4) valid seen via data array
                    rd_word[VALID_BIT] = rd_tag.valid;
                end
                KIND_CTRL: begin
                    rd_word = ctrl;
                end
                KIND_STATUS: begin
                    rd_word = {16'h0000, err_count, 7'h00, last_err};
                end
                default: begin
                    rd_word = 32'h0000_0000;
                end
            endcase
        end
    end

    // Write happens at the completing edge, when the master samples pready high
    assign commit = (state == ST_RESP) && !pend.error && pend.write;

    // The response state blocks a second take while pready is high; the read word is registered at the take edge
    always_comb begin
        next_state = state;
        next_pend = pend;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_pend.kind = dec_kind;
                    next_pend.write = pwrite;
                    next_pend.error = req_fault;
                    next_pend.way = dec_way;
                    next_pend.index = dec_index;
                    // (RQ12) full address and data word
                    next_pend.wdata = pwdata;
                    next_state = ST_RESP;
                end
            end
            ST_RESP: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            pend <= '0;
        end else begin
            state <= next_state;
            pend <= next_pend;
        end
    end

    // Answer: pready is a one-cycle pulse, prdata holds until the next answer
    always_comb begin
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (take) begin
            next_prdata = rd_word;
            next_pready = 1'b1;
            next_pslverr = req_fault;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Control changes only on a completed, accepted write
    always_comb begin
        next_ctrl = ctrl;
        if (commit && pend.kind == KIND_CTRL) begin
            next_ctrl = pend.wdata & CTRL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Count saturates so a storm of refusals cannot wrap it back to zero
    always_comb begin
        next_err_count = err_count;
        next_last_err = last_err;
        if (take) begin
            next_last_err = req_fault;
            if (req_fault && err_count != 8'hff) begin
                next_err_count = err_count + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_count <= 8'h00;
            last_err <= 1'b0;
        end else begin
            err_count <= next_err_count;
            last_err <= next_last_err;
        end
    end

    // Tag fields cut once from the pending word, shared by every way
    always_comb begin
        // (RQ9) tag write fields
        wr_tag.vpn_hi = pend.wdata[VPN_HI_MSB:VPN_HI_LSB];
        wr_tag.vpn_lo = pend.wdata[VPN_LO_MSB:VPN_LO_LSB];
        // Valid sits at the same bit in both words
        wr_tag.valid = pend.wdata[VALID_BIT];
        // (RQ13) space id in bits 7-0
        wr_tag.address_space_id = pend.wdata[ADDRESS_SPACE_ID_MSB:ADDRESS_SPACE_ID_LSB];
    end

    // One storage slice per way; entries clear to invalid at reset
    for (genvar w = 0; w < WAYS; w++) begin : g_way
        tlb_tag_t tag_ram [ENTRIES];
        logic [31:0] data_ram [ENTRIES];
        logic hit_way;
        logic tag_we;
        logic data_we;
        tlb_tag_t next_tag;

        // Reads follow the live address, writes the captured one
        assign way_tag[w] = tag_ram[dec_index];
        assign way_data[w] = data_ram[dec_index];

        always_comb begin
            hit_way = (pend.way == WAY_BITS'(w));
            // (RQ10) way field selects way
            tag_we = commit && hit_way && (pend.kind == KIND_TAG);
            data_we = commit && hit_way && (pend.kind == KIND_DATA);
            next_tag = tag_ram[pend.index];
            if (tag_we) begin
                next_tag = wr_tag;
            end else if (data_we) begin
                // (RQ4) valid written via data array
                next_tag.valid = wr_tag.valid;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                for (int e = 0; e < ENTRIES; e++) begin
                    tag_ram[e] <= '0;
                    data_ram[e] <= 32'h0000_0000;
                end
            end else begin
                if (tag_we || data_we) begin
                    tag_ram[pend.index] <= next_tag;
                end
                if (data_we) begin
                    // (RQ11) full longword write
                    data_ram[pend.index] <= pend.wdata;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/tlb_mm_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tlb_mm_checker
    import tlb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    wire logic req = psel && penable && !pready;
    wire logic hit = paddr[31:25] == 7'h79;
    wire logic reg_hit = paddr == CTRL_OFFSET || paddr == STATUS_OFFSET;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_answer; req |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("access not answered");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("answer held too long");
    property p_priv; req && !pprot[0] |=> pslverr; endproperty
    a_priv: assert property (p_priv) else $error("user access accepted");
    property p_decode; req && !hit && !reg_hit |=> pslverr; endproperty
    a_decode: assert property (p_decode) else $error("stray address accepted");
    property p_size; req && pwrite && pstrb != FULL_STRB |=> pslverr; endproperty
    a_size: assert property (p_size) else $error("partial write accepted");
    property p_ok; req && hit && pprot[0] && pstrb == FULL_STRB |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("array access refused");
    property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refusal leaks data");
    property p_tag_gap; pready && !pwrite && !pslverr && paddr[31:24] == ADDR_ARRAY_SEL
        |-> prdata[16:12] == 5'h0 && !prdata[9]; endproperty
    a_tag_gap: assert property (p_tag_gap) else $error("tag read gap not zero");
    c_tag_rd: cover property (pready && !pwrite && paddr[31:24] == ADDR_ARRAY_SEL);
    c_data_wr: cover property (pready && pwrite && paddr[31:24] == DATA_ARRAY_SEL);
    c_refused: cover property (pready && pslverr);
endmodule
bind tlb_memory_mapped_access tlb_mm_checker checker_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pstrb, .pprot, .prdata, .pready, .pslverr);
`default_nettype wire

// ### verif/core_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [31:0] paddr,
    output var logic [31:0] pwdata,
    output var logic [3:0] pstrb,
    output var logic [2:0] pprot
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        pprot = 3'b001;
    end
    task automatic xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s,
        input logic [2:0] p, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        pprot <= p;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so a stale address never passes
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import tlb_pkg::*;
    localparam logic [31:0] TA = 32'hf200_0000;
    localparam logic [31:0] DA = 32'hf300_0000;
    localparam logic [31:0] JUNK = 32'h00fe_0cff;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] pprot;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #5 pclk = ~pclk;
    core_model core (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pprot);
    tlb_memory_mapped_access DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr);
    function automatic logic [31:0] tv(input int w);
        return 32'h8000_f1ff + (w << 26);
    endfunction
    function automatic logic [31:0] dv(input int w);
        return 32'h5a00_0000 + w * 32'h101;
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [31:0] a, d, input logic [3:0] s,
        input logic [2:0] p, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic e;
        core.xfer(w, a, d, s, p, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask
    task automatic wr(input logic [31:0] a, d);
        acc(1'b1, a, d, 4'hf, 3'b001, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [31:0] a, exp);
        acc(1'b0, a, 32'h0, 4'hf, 3'b001, exp, 1'b0);
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(TA | JUNK, 32'h0);
        rd(CTRL_OFFSET, CTRL_RESET);
        for (int w = 0; w < 4; w++) begin
            wr(TA | (5 << 12) | (w << 8), tv(w));
        end
        wr(TA | 32'h0001_f300, 32'hffff_ffff);
        rd(TA | 32'h0001_f300, 32'hfffe_0dff);
        for (int w = 0; w < 4; w++) begin
            rd(TA | JUNK | (5 << 12) | (w << 8), tv(w) & 32'hfffe_0dff);
            wr(DA | (5 << 12) | (w << 8), dv(w));
            rd(DA | JUNK | (5 << 12) | (w << 8), dv(w));
            rd(TA | (5 << 12) | (w << 8), (tv(w) & 32'hfffe_0cff) | (w % 2) * 32'h100);
        end
        wr(TA | 32'h0000_5200, tv(2));
        rd(DA | 32'h0000_5200, dv(2) | 32'h100);
        wr(CTRL_OFFSET, 32'h0000_0301);
        rd(CTRL_OFFSET, 32'h0000_0301);
        wr(DA | 32'h0000_1000, 32'h1111_2222);
        wr(CTRL_OFFSET, 32'h0);
        rd(DA | 32'h0000_2000, 32'h1111_2222);
        rd(DA | 32'h0000_1000, 32'h0);
        acc(1'b1, DA | 32'h0000_5000, 32'h0, 4'h3, 3'b001, 32'h0, 1'b1);
        rd(DA | 32'h0000_5000, dv(0));
        acc(1'b1, TA | 32'h0000_5000, 32'h0, 4'hf, 3'b000, 32'h0, 1'b1);
        rd(TA | 32'h0000_5000, tv(0) & 32'hfffe_0cff);
        acc(1'b0, 32'hf400_0000, 32'h0, 4'hf, 3'b001, 32'h0, 1'b1);
        acc(1'b1, STATUS_OFFSET, 32'h0, 4'hf, 3'b001, 32'h0, 1'b1);
        rd(STATUS_OFFSET, 32'h0000_0401);
        report_and_stop();
    end
endmodule
`default_nettype wire
